// >>> hw/uies_pkg.sv
// shared constants for the isochronous endpoint status block
package uies_pkg;
  // status word field positions
  localparam int TOG_LSB    = 6;
  localparam int OVF_BIT    = 8;
  localparam int RXKL_BIT   = 9;
  localparam int TXC_BIT    = 10;
  localparam int TXTR_BIT   = 11;
  localparam int FLOW_BIT   = 12;
  localparam int CRC_BIT    = 13;
  localparam int FLUSH_BIT  = 14;
  localparam int BANK_LSB   = 16;
  localparam int BUSY_LSB   = 18;
  localparam int BCNT_LSB   = 20;
  localparam int SHRT_BIT   = 31;
  localparam int BCNT_W     = 11;
  // register offsets
  localparam logic [31:0] STATUS_OFS = 32'hF803C11C;
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_CTRL   = 8'h04;
  localparam logic [7:0]  REG_CMD    = 8'h08;
  localparam logic [7:0]  REG_CFG    = 8'h0C;
  // command bits of REG_CMD (self clearing)
  localparam int CMD_RXCLR  = 0;
  localparam int CMD_TXSET  = 1;
  localparam int CMD_KILL   = 2;
  localparam int CMD_TOGCLR = 3;
  localparam int CMD_EPRST  = 4;
  localparam int CMD_DIS    = 5;
  // transfer type code for isochronous
  localparam logic [1:0] TYPE_ISO = 2'h1;
  // data pid codes, bank count and busy limit
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA1 = 2'h1;
  localparam logic [1:0] PID_DATA2 = 2'h2;
  localparam logic [1:0] PID_MDATA = 2'h3;
  localparam logic [1:0] NUM_BANKS = 2'h3;
  localparam logic [1:0] BUSY_MAX  = 2'h3;
endpackage

// >>> hw/uies_link_if.sv
// link between the endpoint and the host-side bus engine
`timescale 1ns/10ps
interface uies_link_if;
  logic        usbReset;     // bus reset, one-cycle pulse
  logic        rxPacket;     // out packet stored, pulse
  logic [1:0]  rxPid;        // pid of stored packet
  logic [10:0] rxCount;      // bytes of stored packet
  logic        rxCrcErr;     // crc error on stored packet
  logic        rxSeqErr;     // toggle sequencing error of microframe
  logic        inToken;      // in token for the endpoint, pulse
  logic        inSent;       // in packet sent, pulse
  logic        uframeEnd;    // microframe end, pulse
  logic        inBusy;       // device has bank ready to send, level
  modport dev  (input usbReset, rxPacket, rxPid, rxCount, rxCrcErr, rxSeqErr,
                input inToken, uframeEnd, inSent, output inBusy);
  modport host (output usbReset, rxPacket, rxPid, rxCount, rxCrcErr, rxSeqErr,
                output inToken, uframeEnd, input inSent, inBusy);
endinterface

// >>> hw/uies_sat_cnt.sv
// saturating up/down counter used for bank occupancy
`timescale 1ns/10ps
module uies_sat_cnt #(
  parameter int          W   = 2,
  parameter logic [1:0]  MAX = 2'h3
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         clr,
  input  wire logic         up,
  input  wire logic         down,
  output      logic [W-1:0] count
);
  logic [W-1:0] cntQ;
  logic [W-1:0] cntD;
  // up and down together cancel
  assign cntD = clr ? '0 :
                (up && !down && cntQ != W'(MAX)) ? cntQ + W'(1) :
                (down && !up && cntQ != '0) ? cntQ - W'(1) : cntQ;
  assign count = cntQ;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cntQ <= '0;
    else cntQ <= cntD;
  end
endmodule

// >>> hw/uies_device.sv
// isochronous endpoint status logic, device end
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
// How it works
// (R1) view valid only for isochronous type code
// (R2) in toggle gives next sent pid
// (R3) out toggle gives current bank pid
// (R4) out toggle updates on data or clear
// (R5) toggle-clear or disable forces DATA1
// (R6) software checks transaction error for sequencing
// (R7) overflow set on too-long packet
// (R8) received-out set on store, firmware clears
// (R9) received-out rise raises enabled interrupt
// (R10) kill decrements busy, sent sets complete
// (R11) kill with token sends, kills last
// (R12) transmit complete set after in sent
// (R13) packet-ready clears when sent, interrupt
// (R14) transaction error tracks current bank group
// (R15) software discards bad group by clearing
// (R16) flow error on underflow or busy drop
// (R17) crc error re-evaluated on each receive
// (R18) count error when too few validated
// (R19) flush error when unsent banks discarded
// (R20) current bank 0..2 advances on software
// (R21) busy bank count 0..3
// (R22) byte count up, down, reload, clear
// (R23) short packet when count below size
// (R24) usb reset clears all, writes ignored
module uies_device #(
  parameter int AW = 8
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  uies_link_if.dev           link,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wrData,
  input  wire logic          wrStb,
  input  wire logic          rdStb,
  input  wire logic          fifoWr,
  input  wire logic          fifoRd,
  output      logic [31:0]   rdData,
  output      logic          irq
);
  ////////////////////////////////////////////////////////////////////////
  // register decode
  logic        wrCtrl, wrCmd, wrCfg;
  logic [31:0] cmd;
  assign wrCtrl = wrStb && addr == uies_pkg::REG_CTRL;
  assign wrCmd  = wrStb && addr == uies_pkg::REG_CMD;
  assign wrCfg  = wrStb && addr == uies_pkg::REG_CFG;
  assign cmd    = wrCmd ? wrData : 32'h0;

  logic rxClr, txSet, kill, togClr, epRst, dis, usbRst, clrAll;
  assign rxClr  = cmd[uies_pkg::CMD_RXCLR];
  assign txSet  = cmd[uies_pkg::CMD_TXSET];
  assign kill   = cmd[uies_pkg::CMD_KILL];
  assign togClr = cmd[uies_pkg::CMD_TOGCLR];
  assign epRst  = cmd[uies_pkg::CMD_EPRST];
  assign dis    = cmd[uies_pkg::CMD_DIS];
  assign usbRst = link.usbReset;
  assign clrAll = usbRst || epRst || dis;

  // control: [0] rx irq enable, [1] tx irq enable
  // config: [1:0] type, [2] dir in, [3] high bw, [5:4] trans, [16:6] size
  logic [1:0]  ctrlQ;
  logic [16:0] cfgQ;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlQ <= 2'h0;
      cfgQ  <= 17'h0;
    end else begin
      if (wrCtrl) ctrlQ <= wrData[1:0];
      if (wrCfg)  cfgQ  <= wrData[16:0];
    end
  end
  logic        isIso, dirIn, highBw;
  logic [1:0]  nTrans;
  logic [10:0] epSize;
  assign isIso  = cfgQ[1:0] == uies_pkg::TYPE_ISO;
  assign dirIn  = cfgQ[2];
  assign highBw = cfgQ[3];
  assign nTrans = cfgQ[5:4];
  assign epSize = cfgQ[16:6];

  ////////////////////////////////////////////////////////////////////////
  // bank bookkeeping
  logic [1:0] busy;
  logic       outDrop, outStore, inMiss, killOk, killLast, flush;
  assign outStore = !dirIn && link.rxPacket && busy != uies_pkg::BUSY_MAX;
  assign outDrop  = !dirIn && link.rxPacket && busy == uies_pkg::BUSY_MAX; // R16
  assign inMiss   = dirIn && link.inToken && busy == 2'h0; // R16
  // kill refused with no bank busy, or with a single bank in flight on the send
  assign killOk   = dirIn && kill && busy != 2'h0 &&
                    !(link.inSent && busy == 2'h1); // R10 R11
  assign killLast = killOk && link.inSent; // R11
  assign flush    = dirIn && highBw && link.uframeEnd && busy != 2'h0; // R19

  logic up, down, bankClr;
  assign up      = dirIn ? txSet : outStore; // R21
  assign down    = dirIn ? (link.inSent && busy != 2'h0) || killOk
                         : rxClr && busy != 2'h0; // R10
  assign bankClr = clrAll || flush;

  uies_sat_cnt #(.W(2), .MAX(uies_pkg::BUSY_MAX)) busyCnt (
    .mclk   (mclk),
    .reset_n(reset_n),
    .clr    (bankClr),
    .up     (up),
    .down   (down),
    .count  (busy)
  );
  assign link.inBusy = dirIn && busy != 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // status flags
  logic [1:0]  togQ, bankQ;
  logic        ovfQ, rxQ, txcQ, txrQ, trerQ, flowQ, crcQ, flushQ, shrtQ;
  logic [10:0] bcntQ, nextCnt;
  logic [1:0]  validQ;
  logic        sentQ;
  logic [1:0]  nextBank;
  assign nextBank = (bankQ == uies_pkg::NUM_BANKS - 2'h1) ? 2'h0 : bankQ + 2'h1;
  assign nextCnt  = dirIn ? 11'h0 : link.rxCount; // reload for next bank
  // out count and its size flags load when a packet lands in the empty current bank or firmware clears a bank
  logic        loadCnt;
  assign loadCnt  = !dirIn && ((outStore && busy == 2'h0) || rxClr); // R22

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      togQ <= 2'h0; bankQ <= 2'h0; ovfQ <= 1'b0; rxQ <= 1'b0;
      txcQ <= 1'b0; txrQ <= 1'b0; trerQ <= 1'b0; flowQ <= 1'b0;
      crcQ <= 1'b0; flushQ <= 1'b0; shrtQ <= 1'b0; bcntQ <= 11'h0;
      validQ <= 2'h0; sentQ <= 1'b0;
    end else if (usbRst) begin // R24
      togQ <= 2'h0; bankQ <= 2'h0; ovfQ <= 1'b0; rxQ <= 1'b0;
      txcQ <= 1'b0; txrQ <= 1'b0; trerQ <= 1'b0; flowQ <= 1'b0;
      crcQ <= 1'b0; flushQ <= 1'b0; shrtQ <= 1'b0; bcntQ <= 11'h0;
      validQ <= 2'h0; sentQ <= 1'b0;
    end else if (epRst || dis) begin
      if (dis) togQ <= uies_pkg::PID_DATA1; // R5
      bankQ <= 2'h0; ovfQ <= 1'b0; rxQ <= 1'b0; txcQ <= 1'b0; // R7 R12
      txrQ <= 1'b0; trerQ <= 1'b0; flowQ <= 1'b0; crcQ <= 1'b0;
      flushQ <= 1'b0; shrtQ <= 1'b0; validQ <= 2'h0; sentQ <= 1'b0;
      if (epRst) bcntQ <= 11'h0; // R22
    end else begin
      // toggle
      if (togClr) togQ <= uies_pkg::PID_DATA1; // R5
      else if (dirIn && link.inSent) togQ <= ~togQ & 2'h1; // R2
      else if (!dirIn && (outStore || rxClr)) togQ <= link.rxPid; // R3 R4
      // received-out: set wins over clear; stays set with more banks
      if (!dirIn) rxQ <= outStore || (rxQ && !(rxClr && busy <= 2'h1)); // R8
      else if (kill) rxQ <= busy != 2'h0 && !killOk ? 1'b0 : killOk; // R10
      if (dirIn && rxQ && !kill) rxQ <= 1'b0;
      if (outStore) crcQ <= link.rxCrcErr; // R17
      if (loadCnt) begin
        ovfQ  <= link.rxCount > epSize; // R7
        shrtQ <= link.rxCount < epSize; // R23
      end
      if (dirIn && (link.inSent || (kill && !killOk && busy != 2'h0)))
        txcQ <= 1'b1; // R12 R11
      // packet ready clears once no bank waits; trans error in out mode
      if (dirIn) begin
        if (txSet) txrQ <= busy == uies_pkg::BUSY_MAX || busy != 2'h0; // R13
        else if (link.inSent && busy <= 2'h1) txrQ <= 1'b0; // R13
      end else if (highBw && (outStore || rxClr)) begin
        trerQ <= link.rxSeqErr; // R14
      end
      if (outDrop || inMiss) flowQ <= 1'b1; // R16
      if (flush) flushQ <= 1'b1; // R19
      // microframe accounting for high bandwidth in
      if (dirIn && highBw) begin
        if (link.uframeEnd) begin
          if (sentQ && validQ < nTrans) crcQ <= 1'b1; // R18
          validQ <= 2'h0;
          sentQ  <= 1'b0;
        end else begin
          if (txSet && validQ != 2'h3) validQ <= validQ + 2'h1;
          if (link.inSent) sentQ <= 1'b1;
        end
      end
      if (txSet || rxClr) bankQ <= nextBank; // R20
      if (rxClr || txSet) bcntQ <= nextCnt; // R22
      else if (outStore && busy == 2'h0) bcntQ <= link.rxCount; // R22
      else if (fifoWr && bcntQ != 11'h7FF) bcntQ <= bcntQ + 11'h1; // R22
      else if (fifoRd && bcntQ != 11'h0) bcntQ <= bcntQ - 11'h1; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt on received-out rise or packet-ready fall
  logic rxPrevQ, txrPrevQ, irqQ;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxPrevQ <= 1'b0; txrPrevQ <= 1'b0; irqQ <= 1'b0;
    end else begin
      rxPrevQ  <= rxQ;
      txrPrevQ <= txrQ;
      irqQ     <= (ctrlQ[0] && rxQ && !rxPrevQ && !dirIn) ||
                  (ctrlQ[1] && !txrQ && txrPrevQ && dirIn); // R9 R13
    end
  end
  assign irq = irqQ;

  ////////////////////////////////////////////////////////////////////////
  // status word and read port; writes to the status view have no effect
  logic [31:0] status, rdD;
  logic        txrView;
  assign txrView = (dirIn ? txrQ : trerQ);
  assign status = !isIso ? 32'h0 : // R1
    {shrtQ, bcntQ, busy, bankQ, 1'b0, flushQ, crcQ, flowQ, txrView,
     txcQ, rxQ, ovfQ, togQ, 6'h0}; // R24
  assign rdD = !rdStb ? rdData :
               addr == uies_pkg::REG_STATUS ? status :
               addr == uies_pkg::REG_CTRL ? {30'h0, ctrlQ} :
               addr == uies_pkg::REG_CFG ? {15'h0, cfgQ} : 32'h0;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rdData <= 32'h0;
    else rdData <= rdD;
  end
endmodule

// >>> hw/uies_host.sv
// isochronous endpoint status logic, host bus end
`timescale 1ns/10ps
module uies_host (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  uies_link_if.host        link,
  input  wire logic        doReset,
  input  wire logic        doOut,
  input  wire logic [1:0]  outPid,
  input  wire logic [10:0] outCount,
  input  wire logic        outCrcErr,
  input  wire logic        outSeqErr,
  input  wire logic        doIn,
  input  wire logic        doUframeEnd,
  output      logic        inAcked
);
  // register every request so link outputs come from flops
  logic        rstQ, outQ, crcQ, seqQ, inQ, endQ, ackQ;
  logic [1:0]  pidQ;
  logic [10:0] cntQ;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstQ <= 1'b0; outQ <= 1'b0; crcQ <= 1'b0; seqQ <= 1'b0;
      inQ <= 1'b0; endQ <= 1'b0; ackQ <= 1'b0; pidQ <= 2'h0; cntQ <= 11'h0;
    end else begin
      rstQ <= doReset;
      outQ <= doOut;
      pidQ <= outPid;
      cntQ <= outCount;
      crcQ <= outCrcErr;
      seqQ <= outSeqErr;
      inQ  <= doIn;
      endQ <= doUframeEnd;
      ackQ <= inQ && link.inBusy; // token answered when a bank waits
    end
  end
  assign link.usbReset  = rstQ;
  assign link.rxPacket  = outQ;
  assign link.rxPid     = pidQ;
  assign link.rxCount   = cntQ;
  assign link.rxCrcErr  = crcQ;
  assign link.rxSeqErr  = seqQ;
  assign link.inToken   = inQ;
  assign link.uframeEnd = endQ;
  assign inAcked        = ackQ;
endmodule

// >>> verif/uies_chk.sv
// concurrent checks on the endpoint link and the register port
`timescale 1ns/10ps
module uies_chk (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        usbReset,
  input wire logic        rxPacket,
  input wire logic        inSent,
  input wire logic        uframeEnd,
  input wire logic        inBusy,
  input wire logic [7:0]  addr,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [31:0] rdData,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // register decode
  logic mapped;
  assign mapped = addr inside {uies_pkg::REG_STATUS, uies_pkg::REG_CTRL,
                               uies_pkg::REG_CMD, uies_pkg::REG_CFG};
  // bus reset followed by a status read
  sequence sRstRd;
    usbReset ##1 (rdStb && addr == uies_pkg::REG_STATUS);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_USBRST_PULSE: assert property (usbReset |=> !usbReset)
    else $error("bus reset pulse longer than one cycle");
  AST_USBRST_BUSY: assert property (usbReset |=> !inBusy)
    else $error("in busy survives a bus reset");
  AST_USBRST_STATUS: assert property (sRstRd |=> rdData == 32'h0)
    else $error("status not clear after bus reset");
  AST_RD_HOLD: assert property (!rdStb |=> $stable(rdData))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rdStb && !mapped |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_CAUSE: assert property (irq |-> $past(rxPacket, 2) || $past(inSent, 2))
    else $error("interrupt without a receive or send");
  AST_INBUSY_RISE: assert property ($rose(inBusy) |-> $past(wrStb))
    else $error("in busy rose without a software write");
  AST_INBUSY_FALL: assert property ($fell(inBusy) |->
    $past(inSent) || $past(wrStb) || $past(uframeEnd) || $past(usbReset))
    else $error("in busy fell without a cause");
endmodule

// >>> verif/usb_iso_endpoint_status_tb.sv
// bench joining the device and host ends of the endpoint link
`timescale 1ns/10ps
module usb_iso_endpoint_status_tb;
  localparam logic [7:0] ST = 8'h00;
  localparam logic [7:0] CTL = 8'h04;
  localparam logic [7:0] CMD = 8'h08;
  localparam logic [7:0] CFG = 8'h0C;
  logic        mclk = 1'h0, reset_n = 1'h0, sent = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStb = 1'h0, rdStb = 1'h0, fifoWr = 1'h0, fifoRd = 1'h0;
  logic        doReset = 1'h0, doOut = 1'h0, outCrcErr = 1'h0, outSeqErr = 1'h0;
  logic        doIn = 1'h0, doUframeEnd = 1'h0;
  logic [1:0]  outPid = 2'h0;
  logic [10:0] outCount = 11'h000;
  logic [31:0] rdData;
  logic        irq, inAcked;
  int          miscompares = 0, total_checks = 0, irqCnt = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, ends and checker
  always #50 mclk = ~mclk;
  uies_link_if link_inst ();
  assign link_inst.inSent = sent;
  uies_device uies_device_inst (.mclk(mclk), .reset_n(reset_n), .link(link_inst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .fifoWr(fifoWr), .fifoRd(fifoRd),
    .rdData(rdData), .irq(irq));
  uies_host uies_host_inst (.mclk(mclk), .reset_n(reset_n), .link(link_inst),
    .doReset(doReset), .doOut(doOut), .outPid(outPid), .outCount(outCount),
    .outCrcErr(outCrcErr), .outSeqErr(outSeqErr), .doIn(doIn), .doUframeEnd(doUframeEnd),
    .inAcked(inAcked));
  uies_chk uies_chk_inst (.mclk(mclk), .reset_n(reset_n), .usbReset(link_inst.usbReset),
    .rxPacket(link_inst.rxPacket), .inSent(link_inst.inSent), .uframeEnd(link_inst.uframeEnd),
    .inBusy(link_inst.inBusy), .addr(addr), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .irq(irq));
  // interrupt count and run ceiling
  always @(posedge mclk) begin
    if (irq === 1'h1) irqCnt <= irqCnt + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task close_out();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // masked compare of one word
  task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask
  // register write, with an optional sent pulse in the same cycle
  task wr(input logic [7:0] a, input logic [31:0] d, input logic s = 1'h0);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    sent <= s;
    @(posedge mclk);
    wrStb <= 1'h0;
    sent <= 1'h0;
  endtask
  // register read and compare
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge mclk);
    rdStb <= 1'h0;
    #1;
    chk(rdData, e, m);
  endtask
  // host out packet
  task out(input logic [1:0] p, input logic [10:0] n, input logic c, input logic s);
    @(posedge mclk);
    {doOut, outPid, outCount, outCrcErr, outSeqErr} <= {1'h1, p, n, c, s};
    @(posedge mclk);
    doOut <= 1'h0;
  endtask
  // single-cycle events: reset, token, frame end, fifo write, fifo read
  task pl(input logic [4:0] k, input int n);
    repeat (n) begin
      @(posedge mclk);
      {doReset, doIn, doUframeEnd, fifoWr, fifoRd} <= k;
      @(posedge mclk);
      {doReset, doIn, doUframeEnd, fifoWr, fifoRd} <= 5'h00;
    end
  endtask
  // expected status word
  function automatic logic [31:0] sw(input logic [1:0] tg, input logic [6:0] fl,
    input logic [1:0] bk, input logic [1:0] bz, input logic [10:0] bc, input logic sh);
    return {sh, bc, bz, bk, 1'h0, fl, tg, 6'h00};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: idle view, out endpoint, in endpoint
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    wr(ST, 32'hFFFFFFFF);
    rc(ST, 32'h0);
    rc(8'h10, 32'h0);
    wr(CFG, 32'h00001009);
    wr(CTL, 32'h1);
    out(2'h2, 11'h00A, 1'h1, 1'h1);
    rc(ST, sw(2'h2, 7'h2A, 2'h0, 2'h1, 11'h00A, 1'h1));
    pl(5'h01, 3);
    rc(ST, sw(2'h2, 7'h2A, 2'h0, 2'h1, 11'h007, 1'h1));
    out(2'h3, 11'h064, 1'h0, 1'h0);
    wr(CMD, 32'h1);
    rc(ST, sw(2'h3, 7'h03, 2'h1, 2'h1, 11'h0, 1'h0), 32'h800FFFC0);
    repeat (3) out(2'h0, 11'h040, 1'h0, 1'h0);
    wr(CMD, 32'h8);
    rc(ST, sw(2'h1, 7'h13, 2'h1, 2'h3, 11'h0, 1'h0), 32'h800FFFC0);
    wr(CMD, 32'h10);
    rc(ST, 32'h0, 32'hFFF37F00);
    chk(32'(irqCnt), 32'h1, 32'hFFFFFFFF);
    pl(5'h10, 1);
    rc(ST, 32'h0);
    wr(CFG, 32'h0000102D);
    wr(CTL, 32'h2);
    pl(5'h02, 5);
    rc(ST, sw(2'h0, 7'h00, 2'h0, 2'h0, 11'h005, 1'h0), 32'h7FF00000);
    wr(CMD, 32'h2);
    rc(ST, sw(2'h0, 7'h00, 2'h1, 2'h1, 11'h0, 1'h0), 32'h000F0000);
    wr(CMD, 32'h4, 1'h1);
    rc(ST, sw(2'h1, 7'h04, 2'h1, 2'h0, 11'h0, 1'h0), 32'h000F04C0);
    chk(32'(irqCnt), 32'h1, 32'hFFFFFFFF);
    pl(5'h04, 1);
    wr(CTL, 32'h0);
    pl(5'h08, 1);
    repeat (2) wr(CMD, 32'h2);
    pl(5'h04, 1);
    rc(ST, sw(2'h0, 7'h74, 2'h0, 2'h0, 11'h0, 1'h0), 32'h000C7700);
    // packet ready is up here; a send clears it and raises the tx interrupt
    wr(CTL, 32'h2);
    wr(ST, 32'h0, 1'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(irqCnt), 32'h2, 32'hFFFFFFFF);
    close_out();
  end
endmodule
